// ===== core/micro_address_stack_pkg.sv
package micro_address_stack_pkg;

	localparam int ADDR_W = 19;
	localparam int WORD_W = 24;
	localparam int MICRO_W = 16;
	localparam int STACK_DEPTH = 16;
	localparam int PTR_W = 4;
	localparam int LEN_W = 5;
	localparam int LIT_W = 12;
	localparam int NIB_COUNT = 6;

	localparam logic [ADDR_W-1:0] MICRO_STEP = 19'h00010;
	localparam logic [ADDR_W-1:0] MAR_RESET = 19'h00000;
	localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
	localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
	localparam logic [WORD_W-1:0] ALT_MEM_SIZE = 24'h000000;
	localparam logic [WORD_W-1:0] MEM_SIZE_DEFAULT = 24'h080000;

	typedef struct packed {
		logic [3:0] group;
		logic [1:0] sel;
	} reg_code_t;

	localparam reg_code_t RC_OPERAND_FIRST = '{group: 4'h0, sel: 2'h2};
	localparam reg_code_t RC_OPERAND_SECOND = '{group: 4'h1, sel: 2'h2};
	localparam reg_code_t RC_TRANSFORM = '{group: 4'h2, sel: 2'h2};
	localparam reg_code_t RC_LOGIC = '{group: 4'h3, sel: 2'h2};
	localparam reg_code_t RC_MICRO_ADDR = '{group: 4'h4, sel: 2'h2};
	localparam reg_code_t RC_PROT_BASE = '{group: 4'h6, sel: 2'h2};
	localparam reg_code_t RC_PROT_LIMIT = '{group: 4'h7, sel: 2'h2};
	localparam reg_code_t RC_FIELD_ADDR = '{group: 4'h8, sel: 2'h2};
	localparam reg_code_t RC_MEM_SIZE = '{group: 4'h9, sel: 2'h3};
	localparam reg_code_t RC_ALT_MEM_SIZE = '{group: 4'hA, sel: 2'h3};
	localparam reg_code_t RC_STACK_TOP = '{group: 4'hB, sel: 2'h2};
	localparam logic [3:0] TRANSFORM_NIB_GROUP = 4'h0;
	localparam logic [3:0] LOGIC_NIB_GROUP = 4'h8;
	localparam logic [1:0] NIB_SEL = 2'h0;

	localparam logic [1:0] MREG_FIRST = 2'h0;
	localparam logic [1:0] MREG_SECOND = 2'h1;
	localparam logic [1:0] MREG_LOGIC = 2'h2;
	localparam logic [1:0] MREG_TRANSFORM = 2'h3;

	typedef enum logic [3:0] {
		OP_MOVE = 4'h0,
		OP_BRANCH = 4'h1,
		OP_FETCH = 4'h2,
		OP_MEMORY_RW = 4'h3,
		OP_FIELD_COUNT = 4'h4,
		OP_SHIFT_ONE = 4'h5,
		OP_SHIFT_TWO = 4'h6,
		OP_SHIFT_THREE = 4'h7,
		OP_TRANSFORM_SHIFT = 4'h8,
		OP_EXTRACT = 4'h9,
		OP_CALL = 4'hA
	} op_kind_t;

	typedef struct packed {
		op_kind_t kind;
		reg_code_t src;
		reg_code_t dst;
		logic down;
		logic rotate;
		logic left;
		logic mem_write;
		logic [1:0] mem_reg;
		logic [LIT_W-1:0] literal;
	} micro_op_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic rotate;
		logic [ADDR_W-1:0] addr;
		logic [LEN_W-1:0] len;
		logic [WORD_W-1:0] wdata;
	} mem_req_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FETCH = 3'b010,
		ST_DATA = 3'b100
	} seq_state_t;

endpackage

// ===== core/micro_address_stack_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Micro address register is 19 bits, shared by fetch and data addressing.
// - Micro fetch uses address with low four bits zero; loads 16-bit micro.
// - Micro fetch data bypasses the memory rotator.
// - Branch adds or subtracts a 12-bit increment times 16 to the address.
// - Run mode advances the address by 16 per micro; wrap allowed.
// - Memory read/write uses full 19-bit bit address through the rotator.
// - During data access the next micro address is held, then restored.
// - Reading the micro address register drives all its bits onto the exchange.
// - Writing the micro address copies low 19 bits of the source and counts as a branch.
// - Stack-top write increments the pointer, then stores at the new entry.
// - Stack-top read delivers the current entry, then decrements the pointer.
// - Return stack: 16 entries of 24 bits, LIFO, pointer wraps modulo 16.
// - Return is a move from stack top into the micro address register.
// - Installed memory size is a wired 24-bit constant; writes ignored.
// - Base and limit are 24-bit read/write; no access blocking here.
// - Alternate memory size reads as all zeros.
// - Both operands, logic and transform registers take memory data.
// - Shift micros: first operand three, second two, transform shift and extract.
// - Logic and transform registers also addressable as six 4-bit groups.
// - Memory micro counts field address by literal, or length field if zero.
// - Field count micro counts field address up or down by its variant.
// - Memory operations load low 19 bits of field address into micro address.
// - Length field is five bits, lengths one to twenty-four.
// - Registers picked by 16-group coordinate and four-way select coordinate.
module micro_address_stack_regs
	import micro_address_stack_pkg::*;
#(
	parameter logic [WORD_W-1:0] INSTALLED_MEMORY_SIZE = MEM_SIZE_DEFAULT
)
(
	input  wire logic                 mclk,
	input  wire logic                 reset,
	input  wire logic                 op_valid,
	input  wire micro_op_t            op,
	output logic                      op_ready,
	input  wire logic                 run_mode,
	input  wire logic [LEN_W-1:0]     operand_length_field,
	input  wire logic [WORD_W-1:0]    ext_src_data,
	output logic [WORD_W-1:0]         mex_bus,
	output logic                      branch_taken,
	output mem_req_t                  mem_req,
	input  wire logic                 mem_ack,
	input  wire logic [WORD_W-1:0]    mem_rdata,
	output logic [MICRO_W-1:0]        micro_instr,
	output logic [ADDR_W-1:0]         micro_program_address,
	output logic [PTR_W-1:0]          stack_ptr
);

	seq_state_t                       st_r;
	logic [ADDR_W-1:0]                mar_r;
	logic [ADDR_W-1:0]                next_address_hold;
	logic [PTR_W-1:0]                 ptr_r;
	logic [WORD_W-1:0]                stack_mem [STACK_DEPTH];
	logic [WORD_W-1:0]                first_r;
	logic [WORD_W-1:0]                second_r;
	logic [WORD_W-1:0]                logic_r;
	logic [WORD_W-1:0]                transform_r;
	logic [WORD_W-1:0]                base_r;
	logic [WORD_W-1:0]                limit_r;
	logic [WORD_W-1:0]                fa_r;
	logic [MICRO_W-1:0]               micro_r;
	logic [WORD_W-1:0]                mex_r;
	logic                             branch_r;
	mem_req_t                         req_r;
	micro_op_t                        pend_r;

	logic                             go;
	logic                             move_go;
	logic [WORD_W-1:0]                src_val;
	logic [WORD_W-1:0]                mem_wval;
	logic [ADDR_W-1:0]                branch_step;
	logic [LEN_W-1:0]                 step_len;
	logic [LEN_W-1:0]                 pend_len;
	logic                             data_done;
	logic                             fetch_done;
	logic [3:0]                       t_nib;
	logic [3:0]                       l_nib;

	// Hit flag in bit 3, group index in bits 2:0
	function automatic logic [3:0] nib_slot(reg_code_t c, logic [3:0] base);
		logic [3:0] off;
		off = c.group - base;
		nib_slot = {(c.sel == NIB_SEL) && (c.group >= base) && (off < 4'(NIB_COUNT)),
			off[2:0]};
	endfunction

	function automatic logic [WORD_W-1:0] nib_put(logic [WORD_W-1:0] v,
		logic [2:0] idx, logic [3:0] d);
		logic [WORD_W-1:0] r;
		r = v;
		r[WORD_W-1-4*idx -: 4] = d;
		nib_put = r;
	endfunction

	function automatic logic [WORD_W-1:0] shift24(logic [WORD_W-1:0] v,
		logic [4:0] amt, logic left, logic rot);
		logic [2*WORD_W-1:0] d;
		d = {v, v};
		if (left)
		begin
			d = d << amt;
			shift24 = rot ? d[2*WORD_W-1:WORD_W] : v << amt;
		end
		else
		begin
			d = d >> amt;
			shift24 = rot ? d[WORD_W-1:0] : v >> amt;
		end
	endfunction

	function automatic logic [WORD_W-1:0] mreg_val(logic [1:0] s, logic [WORD_W-1:0] x,
		logic [WORD_W-1:0] y, logic [WORD_W-1:0] l, logic [WORD_W-1:0] t);
		case (s)
			MREG_FIRST:  mreg_val = x;
			MREG_SECOND: mreg_val = y;
			MREG_LOGIC:  mreg_val = l;
			default:     mreg_val = t;
		endcase
	endfunction

	assign go = op_valid && (st_r == ST_IDLE);
	assign move_go = go && (op.kind == OP_MOVE);
	assign op_ready = (st_r == ST_IDLE);
	assign data_done = (st_r == ST_DATA) && mem_ack;
	assign fetch_done = (st_r == ST_FETCH) && mem_ack;
	assign branch_step = {3'h0, op.literal, 4'h0};
	assign step_len = (op.literal[LEN_W-1:0] == '0) ? operand_length_field
		: op.literal[LEN_W-1:0];
	assign pend_len = (pend_r.literal[LEN_W-1:0] == '0) ? operand_length_field
		: pend_r.literal[LEN_W-1:0];
	assign t_nib = nib_slot(op.src, TRANSFORM_NIB_GROUP);
	assign l_nib = nib_slot(op.src, LOGIC_NIB_GROUP);
	assign mem_wval = mreg_val(op.mem_reg, first_r, second_r, logic_r, transform_r);

	// Source selection by group and select coordinates
	always_comb
	begin
		src_val = ext_src_data;
		if (t_nib[3])
			src_val = {20'h00000, transform_r[WORD_W-1-4*t_nib[2:0] -: 4]};
		else if (l_nib[3])
			src_val = {20'h00000, logic_r[WORD_W-1-4*l_nib[2:0] -: 4]};
		else
		begin
			case (op.src)
				RC_OPERAND_FIRST:  src_val = first_r;
				RC_OPERAND_SECOND: src_val = second_r;
				RC_TRANSFORM:      src_val = transform_r;
				RC_LOGIC:          src_val = logic_r;
				RC_MICRO_ADDR:     src_val = {5'h00, mar_r};
				RC_PROT_BASE:      src_val = base_r;
				RC_PROT_LIMIT:     src_val = limit_r;
				RC_FIELD_ADDR:     src_val = fa_r;
				RC_MEM_SIZE:       src_val = INSTALLED_MEMORY_SIZE;
				RC_ALT_MEM_SIZE:   src_val = ALT_MEM_SIZE;
				RC_STACK_TOP:      src_val = stack_mem[ptr_r];
				default:           src_val = ext_src_data;
			endcase
		end
	end

	// Sequencer for fetch and data memory cycles
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			st_r <= ST_IDLE;
		else
		begin
			case (st_r)
				ST_IDLE:
					if (go && op.kind == OP_FETCH)
						st_r <= ST_FETCH;
					else if (go && op.kind == OP_MEMORY_RW)
						st_r <= ST_DATA;
				ST_FETCH:
					if (mem_ack)
						st_r <= ST_IDLE;
				ST_DATA:
					if (mem_ack)
						st_r <= ST_IDLE;
				default:
					st_r <= ST_IDLE;
			endcase
		end
	end

	// Memory request, held until acknowledged
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			req_r <= '0;
			pend_r <= '0;
		end
		else if (go && op.kind == OP_FETCH)
		begin
			req_r <= '0;
			req_r.rd <= 1'b1;
			req_r.rotate <= 1'b0;
			req_r.addr <= {mar_r[ADDR_W-1:4], 4'h0};
			req_r.len <= 5'(MICRO_W);
		end
		else if (go && op.kind == OP_MEMORY_RW)
		begin
			pend_r <= op;
			req_r.rd <= !op.mem_write;
			req_r.wr <= op.mem_write;
			req_r.rotate <= 1'b1;
			req_r.addr <= fa_r[ADDR_W-1:0];
			req_r.len <= step_len;
			req_r.wdata <= mem_wval;
		end
		else if (mem_ack)
		begin
			req_r.rd <= 1'b0;
			req_r.wr <= 1'b0;
		end
	end

	// Micro instruction register
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			micro_r <= '0;
		else if (fetch_done)
			micro_r <= mem_rdata[MICRO_W-1:0];
	end

	// Shared micro program / memory address register
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			mar_r <= MAR_RESET;
			next_address_hold <= MAR_RESET;
			branch_r <= 1'b0;
		end
		else
		begin
			branch_r <= 1'b0;
			if (data_done)
				mar_r <= next_address_hold;
			else if (fetch_done && run_mode)
				mar_r <= mar_r + MICRO_STEP;
			else if (go && op.kind == OP_MEMORY_RW)
			begin
				next_address_hold <= mar_r;
				mar_r <= fa_r[ADDR_W-1:0];
			end
			else if (move_go && op.dst == RC_MICRO_ADDR)
			begin
				mar_r <= src_val[ADDR_W-1:0];
				branch_r <= 1'b1;
			end
			else if (go && (op.kind == OP_BRANCH || op.kind == OP_CALL))
			begin
				mar_r <= op.down ? mar_r - branch_step : mar_r + branch_step;
				branch_r <= 1'b1;
			end
		end
	end

	// Return stack pointer, wraps modulo sixteen
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			ptr_r <= PTR_RESET;
		else if (go && op.kind == OP_CALL)
			ptr_r <= ptr_r + 4'h1;
		else if (move_go)
			ptr_r <= ptr_r + 4'(op.dst == RC_STACK_TOP)
				- 4'(op.src == RC_STACK_TOP);
	end

	// Return stack storage, no reset
	always_ff @(posedge mclk)
	begin
		if (go && op.kind == OP_CALL)
			stack_mem[ptr_r + 4'h1] <= {5'h00, mar_r};
		else if (move_go && op.dst == RC_STACK_TOP)
			stack_mem[ptr_r + 4'h1] <= src_val;
	end

	// First operand register
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			first_r <= WORD_RESET;
		else if (data_done && !pend_r.mem_write && pend_r.mem_reg == MREG_FIRST)
			first_r <= mem_rdata;
		else if (move_go && op.dst == RC_OPERAND_FIRST)
			first_r <= src_val;
		else if (go && !op.mem_reg[0] && (op.kind == OP_SHIFT_ONE
			|| op.kind == OP_SHIFT_TWO))
			first_r <= shift24(first_r, op.literal[4:0], op.left, op.rotate);
		else if (go && op.kind == OP_SHIFT_THREE)
			first_r <= shift24(first_r, op.literal[4:0], op.left, op.rotate);
	end

	// Second operand register
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			second_r <= WORD_RESET;
		else if (data_done && !pend_r.mem_write && pend_r.mem_reg == MREG_SECOND)
			second_r <= mem_rdata;
		else if (move_go && op.dst == RC_OPERAND_SECOND)
			second_r <= src_val;
		else if (go && op.mem_reg[0] && (op.kind == OP_SHIFT_ONE
			|| op.kind == OP_SHIFT_TWO))
			second_r <= shift24(second_r, op.literal[4:0], op.left, op.rotate);
	end

	// Logic register, whole word or nibble groups
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			logic_r <= WORD_RESET;
		else if (data_done && !pend_r.mem_write && pend_r.mem_reg == MREG_LOGIC)
			logic_r <= mem_rdata;
		else if (move_go && op.dst == RC_LOGIC)
			logic_r <= src_val;
		else if (move_go && nib_slot(op.dst, LOGIC_NIB_GROUP) >= 4'h8)
			logic_r <= nib_put(logic_r, 3'(nib_slot(op.dst, LOGIC_NIB_GROUP)),
				src_val[3:0]);
	end

	// Transform register, nibble groups, shift and extract
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			transform_r <= WORD_RESET;
		else if (data_done && !pend_r.mem_write && pend_r.mem_reg == MREG_TRANSFORM)
			transform_r <= mem_rdata;
		else if (move_go && op.dst == RC_TRANSFORM)
			transform_r <= src_val;
		else if (move_go && nib_slot(op.dst, TRANSFORM_NIB_GROUP) >= 4'h8)
			transform_r <= nib_put(transform_r,
				3'(nib_slot(op.dst, TRANSFORM_NIB_GROUP)), src_val[3:0]);
		else if (go && op.kind == OP_TRANSFORM_SHIFT)
			transform_r <= shift24(transform_r, op.literal[4:0], op.left, op.rotate);
		else if (go && op.kind == OP_EXTRACT)
			transform_r <= (transform_r >> op.literal[4:0])
				& ~({WORD_W{1'b1}} << op.literal[9:5]);
	end

	// Base and limit; range checking is left to software
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			base_r <= WORD_RESET;
			limit_r <= WORD_RESET;
		end
		else if (move_go && op.dst == RC_PROT_BASE)
			base_r <= src_val;
		else if (move_go && op.dst == RC_PROT_LIMIT)
			limit_r <= src_val;
	end

	// Field bit address register with up/down counting
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			fa_r <= WORD_RESET;
		else if (data_done)
			fa_r <= pend_r.down ? fa_r - 24'(pend_len) : fa_r + 24'(pend_len);
		else if (move_go && op.dst == RC_FIELD_ADDR)
			fa_r <= src_val;
		else if (go && op.kind == OP_FIELD_COUNT)
			fa_r <= op.down ? fa_r - 24'(step_len) : fa_r + 24'(step_len);
	end

	// Main exchange capture of each move
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			mex_r <= WORD_RESET;
		else if (move_go)
			mex_r <= src_val;
	end

	assign mex_bus = mex_r;
	assign branch_taken = branch_r;
	assign mem_req = req_r;
	assign micro_instr = micro_r;
	assign micro_program_address = mar_r;
	assign stack_ptr = ptr_r;

endmodule // micro_address_stack_regs

// ===== tb/micro_address_stack_mem.sv
`timescale 1ns/1ps
module micro_address_stack_mem
	import micro_address_stack_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              reset,
	input  wire mem_req_t          mem_req,
	output logic                   mem_ack,
	output logic [WORD_W-1:0]      mem_rdata
);
	logic [1:0]        wait_r;
	logic [WORD_W-1:0] last_wr;
	// Random latency; read data is only valid in the acknowledge cycle
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			mem_ack <= 1'b0;
			wait_r <= 2'h0;
			mem_rdata <= 24'h000000;
		end
		else
		begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if ((mem_req.rd || mem_req.wr) && !mem_ack)
			begin
				if (wait_r == 2'h0)
				begin
					mem_ack <= 1'b1;
					mem_rdata <= {5'h15, mem_req.addr};
					wait_r <= 2'($urandom);
				end
				else
					wait_r <= wait_r - 2'h1;
			end
		end
	end
	always_ff @(posedge mclk)
	begin
		if (mem_req.wr && mem_ack)
			last_wr <= mem_req.wdata;
	end
endmodule // micro_address_stack_mem

// ===== tb/micro_address_stack_props.sv
`timescale 1ns/1ps
module micro_address_stack_props
	import micro_address_stack_pkg::*;
#(
	parameter logic [WORD_W-1:0] INSTALLED_MEMORY_SIZE = MEM_SIZE_DEFAULT
)
(
	input  wire logic                mclk,
	input  wire logic                reset,
	input  wire logic                op_valid,
	input  wire micro_op_t           op,
	input  wire logic                op_ready,
	input  wire logic                run_mode,
	input  wire logic [WORD_W-1:0]   mex_bus,
	input  wire logic                branch_taken,
	input  wire mem_req_t            mem_req,
	input  wire logic                mem_ack,
	input  wire logic [WORD_W-1:0]   mem_rdata,
	input  wire logic [MICRO_W-1:0]  micro_instr,
	input  wire logic [ADDR_W-1:0]   micro_program_address,
	input  wire logic [PTR_W-1:0]    stack_ptr
);
	logic              go;
	logic              mv;
	logic              fdone;
	logic [ADDR_W-1:0] held_r;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	assign go = op_valid && op_ready;
	assign mv = go && op.kind == OP_MOVE;
	assign fdone = mem_req.rd && !mem_req.rotate && mem_ack;
	// Address in force when a data access is taken
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			held_r <= MAR_RESET;
		else if (go && op.kind == OP_MEMORY_RW)
			held_r <= micro_program_address;
	end
	a_move_branch:
	assert property (mv && op.dst == RC_MICRO_ADDR |=> branch_taken
		&& micro_program_address == mex_bus[ADDR_W-1:0]) else $error("move to address");
	a_branch_step:
	assert property (go && op.kind == OP_BRANCH |=> micro_program_address == $past(op.down
		? micro_program_address - {op.literal, 4'h0} : micro_program_address + {op.literal, 4'h0}))
		else $error("branch step");
	a_fetch_addr:
	assert property (go && op.kind == OP_FETCH |=> mem_req.rd && !mem_req.rotate
		&& mem_req.addr == {micro_program_address[ADDR_W-1:4], 4'h0} && mem_req.len == 5'h10)
		else $error("fetch request");
	a_fetch_advance:
	assert property (fdone |=> micro_instr == $past(mem_rdata[MICRO_W-1:0]) && micro_program_address
		== $past(micro_program_address + (run_mode ? MICRO_STEP : MAR_RESET)))
		else $error("fetch result");
	a_data_addr:
	assert property (go && op.kind == OP_MEMORY_RW |=> mem_req.rotate && (mem_req.rd ^ mem_req.wr)
		&& mem_req.addr == micro_program_address) else $error("data request");
	a_addr_restore:
	assert property (mem_req.rotate && mem_ack && (mem_req.rd || mem_req.wr)
		|=> micro_program_address == held_r) else $error("address not restored");
	a_push_ptr:
	assert property (mv && op.dst == RC_STACK_TOP && op.src != RC_STACK_TOP
		|=> stack_ptr == $past(stack_ptr) + 4'h1) else $error("push pointer");
	a_pop_ptr:
	assert property (mv && op.src == RC_STACK_TOP && op.dst != RC_STACK_TOP
		|=> stack_ptr == $past(stack_ptr) - 4'h1) else $error("pop pointer");
	a_size_const:
	assert property (mv && op.src == RC_MEM_SIZE |=> mex_bus == INSTALLED_MEMORY_SIZE)
		else $error("memory size");
	c_push: cover property (mv && op.dst == RC_STACK_TOP);
	c_fetch: cover property (fdone && run_mode);
	c_data: cover property (mem_req.rotate && mem_ack);
endmodule // micro_address_stack_props

// ===== tb/micro_address_stack_regs_tb.sv
`timescale 1ns/1ps
module micro_address_stack_regs_tb;
	import micro_address_stack_pkg::*;
	localparam logic [WORD_W-1:0] MSIZE = 24'h0C0000;
	localparam reg_code_t NUL = '{group: 4'hF, sel: 2'h3};
	logic               mclk;
	logic               reset;
	logic               op_valid;
	logic               op_ready;
	logic               run_mode;
	logic               branch_taken;
	logic               mem_ack;
	micro_op_t          op;
	mem_req_t           mem_req;
	logic [LEN_W-1:0]   len_fld;
	logic [WORD_W-1:0]  src_d;
	logic [WORD_W-1:0]  mex_bus;
	logic [WORD_W-1:0]  mem_rdata;
	logic [MICRO_W-1:0] micro_instr;
	logic [ADDR_W-1:0]  mar;
	logic [PTR_W-1:0]   stack_ptr;
	int                 error_cnt;
	int                 checks_done;
	int                 mar_m;
	int                 ptr_m;
	int                 fa_m;
	logic [WORD_W-1:0]  q [$];
	reg_code_t          rw_codes [7] = '{RC_OPERAND_FIRST, RC_OPERAND_SECOND, RC_TRANSFORM,
		RC_LOGIC, RC_PROT_BASE, RC_PROT_LIMIT, RC_FIELD_ADDR};
	reg_code_t          mem_codes [4] = '{RC_OPERAND_FIRST, RC_OPERAND_SECOND, RC_LOGIC,
		RC_TRANSFORM};

	micro_address_stack_regs #(.INSTALLED_MEMORY_SIZE(MSIZE)) i_dut (.mclk(mclk), .reset(reset),
		.op_valid(op_valid), .op(op), .op_ready(op_ready), .run_mode(run_mode),
		.operand_length_field(len_fld), .ext_src_data(src_d), .mex_bus(mex_bus),
		.branch_taken(branch_taken), .mem_req(mem_req), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .micro_instr(micro_instr), .micro_program_address(mar),
		.stack_ptr(stack_ptr));
	micro_address_stack_mem i_mem (.mclk(mclk), .reset(reset), .mem_req(mem_req),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial
	begin
		#200000;
		error_cnt++;
		summarize();
	end

	task automatic chk(logic [WORD_W-1:0] seen, logic [WORD_W-1:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic micro_op_t mk(op_kind_t k, reg_code_t s, reg_code_t d, int lit);
		micro_op_t o;
		o = '0;
		o.kind = k;
		o.src = s;
		o.dst = d;
		o.literal = lit[LIT_W-1:0];
		return o;
	endfunction

	// Offer one op, hold it until taken, then wait for the sequencer to go idle
	task automatic run(micro_op_t o, logic [WORD_W-1:0] d);
		@(posedge mclk) #1;
		op_valid = 1'b1;
		op = o;
		src_d = d;
		for (int n = 0; n < 50 && op_ready !== 1'b1; n++) @(posedge mclk) #1;
		@(posedge mclk) #1;
		op_valid = 1'b0;
		src_d = 24'($urandom);
		for (int n = 0; n < 50 && op_ready !== 1'b1; n++) @(posedge mclk) #1;
		chk(24'(op_ready), 24'h000001);
	endtask

	task automatic mv(reg_code_t d, logic [WORD_W-1:0] v);
		run(mk(OP_MOVE, NUL, d, 0), v);
	endtask

	task automatic rdchk(reg_code_t c, logic [WORD_W-1:0] exp);
		run(mk(OP_MOVE, c, NUL, 0), 24'h000000);
		chk(mex_bus, exp);
	endtask

	initial
	begin
		logic [WORD_W-1:0] v;
		micro_op_t o;
		reg_code_t nc;
		int lit;
		logic [WORD_W-1:0] e;
		void'($urandom(93621));
		reset = 1'b1;
		op_valid = 1'b0;
		op = '0;
		run_mode = 1'b0;
		len_fld = 5'h01;
		src_d = 24'h000000;
		repeat (4) @(posedge mclk);
		#1;
		reset = 1'b0;
		chk(24'(mar), 24'h000000);
		chk(24'(stack_ptr), 24'(PTR_RESET));
		$display("test reset done");
		foreach (rw_codes[i])
		begin
			v = 24'($urandom);
			mv(rw_codes[i], v);
			rdchk(rw_codes[i], v);
		end
		mv(RC_MEM_SIZE, 24'($urandom));
		rdchk(RC_MEM_SIZE, MSIZE);
		rdchk(RC_ALT_MEM_SIZE, 24'h000000);
		for (int j = 0; j < 2; j++)
		begin
			v = 24'($urandom);
			mv(j ? RC_LOGIC : RC_TRANSFORM, v);
			for (int k = 0; k < NIB_COUNT; k++)
			begin
				lit = $urandom;
				nc.group = 4'(k) + (j ? LOGIC_NIB_GROUP : TRANSFORM_NIB_GROUP);
				nc.sel = NIB_SEL;
				mv(nc, {20'h00000, lit[3:0]});
				v[23 - 4 * k -: 4] = lit[3:0];
				rdchk(nc, {20'h00000, lit[3:0]});
			end
			rdchk(j ? RC_LOGIC : RC_TRANSFORM, v);
		end
		$display("test registers done");
		v = 24'($urandom) | 24'h07F000;
		mv(RC_MICRO_ADDR, v);
		mar_m = int'(v[18:0]);
		chk(24'(mar), 24'(v[18:0]));
		chk(24'(branch_taken), 24'h000001);
		rdchk(RC_MICRO_ADDR, 24'(v[18:0]));
		for (int i = 0; i < 6; i++)
		begin
			lit = (i < 2) ? 4095 : $urandom_range(4095);
			o = mk(OP_BRANCH, NUL, NUL, lit);
			o.down = i[0];
			run(o, 24'h000000);
			mar_m = (mar_m + (i[0] ? -16 * lit : 16 * lit)) & 32'h0007FFFF;
			chk(24'(mar), 24'(mar_m));
		end
		$display("test branch done");
		ptr_m = 0;
		for (int i = 0; i < 17; i++)
		begin
			v = 24'($urandom);
			q.push_back(v);
			mv(RC_STACK_TOP, v);
			ptr_m = (ptr_m + 1) % STACK_DEPTH;
			chk(24'(stack_ptr), 24'(ptr_m));
		end
		for (int i = 0; i < 16; i++)
		begin
			rdchk(RC_STACK_TOP, q.pop_back());
			ptr_m = (ptr_m + 15) % STACK_DEPTH;
			chk(24'(stack_ptr), 24'(ptr_m));
		end
		v = 24'($urandom);
		mv(RC_STACK_TOP, v);
		run(mk(OP_MOVE, RC_STACK_TOP, RC_MICRO_ADDR, 0), 24'h000000);
		chk(24'(mar), 24'(v[18:0]));
		chk(24'(branch_taken), 24'h000001);
		$display("test stack done");
		mv(RC_MICRO_ADDR, 24'h07FFF5);
		mar_m = 32'h0007FFF5;
		for (int i = 0; i < 4; i++)
		begin
			run_mode = !i[0];
			run(mk(OP_FETCH, NUL, NUL, 0), 24'h000000);
			chk(24'(micro_instr), 24'({mar_m[15:4], 4'h0}));
			mar_m = (mar_m + (run_mode ? 16 : 0)) & 32'h0007FFFF;
			chk(24'(mar), 24'(mar_m));
		end
		$display("test fetch done");
		v = 24'($urandom);
		mv(RC_OPERAND_FIRST, v);
		fa_m = $urandom & 32'h00FFFFFF;
		mv(RC_FIELD_ADDR, 24'(fa_m));
		for (int r = 0; r < 7; r++)
		begin
			lit = (r == 2 || r == 4) ? 0 : 6 + r;
			len_fld = 5'($urandom_range(24, 1));
			o = mk(r < 4 ? OP_MEMORY_RW : OP_FIELD_COUNT, NUL, NUL, lit);
			o.mem_reg = 2'(r);
			o.mem_write = (r == 0);
			o.down = r[0];
			run(o, 24'h000000);
			chk(24'(mar), 24'(mar_m));
			if (r == 0)
				chk(i_mem.last_wr, v);
			else if (r < 4)
				rdchk(mem_codes[r], {5'h15, 19'(fa_m)});
			fa_m = fa_m + (r[0] ? -1 : 1) * (lit != 0 ? lit : int'(len_fld));
			fa_m = fa_m & 32'h00FFFFFF;
			rdchk(RC_FIELD_ADDR, 24'(fa_m));
		end
		$display("test memory done");
		v = 24'($urandom);
		mv(RC_OPERAND_FIRST, v);
		mv(RC_OPERAND_SECOND, v);
		mv(RC_TRANSFORM, v);
		lit = $urandom_range(23, 1);
		o = mk(OP_SHIFT_ONE, NUL, NUL, lit);
		o.left = 1'b1;
		o.rotate = 1'b1;
		run(o, 24'h000000);
		e = (v << lit) | (v >> (24 - lit));
		rdchk(RC_OPERAND_FIRST, e);
		o = mk(OP_SHIFT_TWO, NUL, NUL, lit);
		o.mem_reg = MREG_SECOND;
		run(o, 24'h000000);
		rdchk(RC_OPERAND_SECOND, v >> lit);
		o = mk(OP_SHIFT_THREE, NUL, NUL, lit);
		o.left = 1'b1;
		run(o, 24'h000000);
		rdchk(RC_OPERAND_FIRST, e << lit);
		o = mk(OP_TRANSFORM_SHIFT, NUL, NUL, lit);
		o.rotate = 1'b1;
		run(o, 24'h000000);
		e = (v >> lit) | (v << (24 - lit));
		rdchk(RC_TRANSFORM, e);
		run(mk(OP_EXTRACT, NUL, NUL, 229), 24'h000000);
		rdchk(RC_TRANSFORM, (e >> 5) & 24'h00007F);
		lit = $urandom_range(4095);
		run(mk(OP_CALL, NUL, NUL, lit), 24'h000000);
		chk(24'(branch_taken), 24'h000001);
		chk(24'(stack_ptr), 24'((ptr_m + 1) % STACK_DEPTH));
		rdchk(RC_STACK_TOP, 24'(mar_m));
		chk(24'(stack_ptr), 24'(ptr_m));
		mar_m = (mar_m + 16 * lit) & 32'h0007FFFF;
		chk(24'(mar), 24'(mar_m));
		$display("test shift and call done");
		summarize();
	end
endmodule // micro_address_stack_regs_tb

bind micro_address_stack_regs micro_address_stack_props
	#(.INSTALLED_MEMORY_SIZE(INSTALLED_MEMORY_SIZE)) i_props (.mclk, .reset, .op_valid, .op,
	.op_ready, .run_mode, .mex_bus, .branch_taken, .mem_req, .mem_ack, .mem_rdata,
	.micro_instr, .micro_program_address, .stack_ptr);
